// *** shared/mii_rx_pkg.sv ***
// constants and types for the expansion-port mii receive link
// assumes a 100 mhz system clock on both ends of the link
package mii_rx_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int RXCLK_100_NS = 40;
    localparam int RXCLK_10_NS = 400;
    localparam int DIV_W = 6;
    // half periods of the generated receive clock, in system cycles
    localparam logic [DIV_W-1:0] HALF_100_CYC = DIV_W'(RXCLK_100_NS / (2 * CLK_PERIOD_NS));
    localparam logic [DIV_W-1:0] HALF_10_CYC = DIV_W'(RXCLK_10_NS / (2 * CLK_PERIOD_NS));
    localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;
    localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;

    // ************************************************************
    // data path
    // ************************************************************
    localparam int NIB_W = 4;
    localparam int FIFO_WIDTH = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
    localparam int STRAP_ROLE_BIT = 0;
    localparam logic [1:0] STRAP_RESET = 2'h0;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {
        ROLE_MAC = 1'b0,
        ROLE_PCS = 1'b1
    } role_type;

    typedef enum logic [1:0] {
        BOOT_SYNC0 = 2'b00,
        BOOT_SYNC1 = 2'b01,
        BOOT_LATCH = 2'b10,
        BOOT_RUN = 2'b11
    } boot_type;

endpackage : mii_rx_pkg

// *** shared/mii_rx_link_if.sv ***
// shared receive-side pins between the switch port and its partner
// assumes at most one end enables its drivers; undriven pins pull low
`timescale 1ns/1ps
interface mii_rx_link_if;

    // ************************************************************
    // per-end drivers and enables
    // ************************************************************
    logic dev_oe;
    logic phy_role_rx_clock_out;
    logic [3:0] phy_role_rx_nibble_out;
    logic phy_role_rx_valid_out;
    logic phy_role_carrier_out;
    logic phy_role_collision_out;
    logic far_oe;
    logic far_clock_o;
    logic [3:0] far_nibble_o;
    logic far_valid_o;
    logic far_error_o;
    logic far_carrier_o;
    logic far_collision_o;

    // ************************************************************
    // resolved pin levels, pull-down when nobody drives
    // ************************************************************
    logic mac_role_rx_clock_in;
    logic [3:0] mac_role_rx_nibble_in;
    logic mac_role_rx_valid_in;
    logic expansion_rx_symbol_error;
    logic mac_role_carrier_in;
    logic mac_role_collision_in;

    // device wins a drive fight only by design error; both enabled is illegal
    assign mac_role_rx_clock_in = dev_oe ? phy_role_rx_clock_out : (far_oe & far_clock_o);
    assign mac_role_rx_nibble_in = dev_oe ? phy_role_rx_nibble_out :
                                   (far_oe ? far_nibble_o : 4'h0);
    assign mac_role_rx_valid_in = dev_oe ? phy_role_rx_valid_out : (far_oe & far_valid_o);
    assign expansion_rx_symbol_error = far_oe & far_error_o;
    assign mac_role_carrier_in = dev_oe ? phy_role_carrier_out : (far_oe & far_carrier_o);
    assign mac_role_collision_in = dev_oe ? phy_role_collision_out :
                                   (far_oe & far_collision_o);

    modport dev_end (
        input mac_role_rx_clock_in, mac_role_rx_nibble_in, mac_role_rx_valid_in,
        input expansion_rx_symbol_error, mac_role_carrier_in, mac_role_collision_in,
        output dev_oe, phy_role_rx_clock_out, phy_role_rx_nibble_out,
        output phy_role_rx_valid_out, phy_role_carrier_out, phy_role_collision_out
    );

    modport far_end (
        input mac_role_rx_clock_in, mac_role_rx_nibble_in, mac_role_rx_valid_in,
        input mac_role_carrier_in, mac_role_collision_in,
        output far_oe, far_clock_o, far_nibble_o, far_valid_o, far_error_o,
        output far_carrier_o, far_collision_o
    );

endinterface : mii_rx_link_if

// *** rtl/mii_rx_port_device.sv ***
// switch expansion port, receive side, in mac-type or pcs-type role
// assumes the interface resolves pins and the partner takes the other role
//
// Overview of operation
// [RULE1] mac role: sample nibble on rising clock
// [RULE2] pcs role: drive nibble aligned to clock
// [RULE3] mac role: accept nibble only while valid
// [RULE4] pcs role: valid high exactly with nibbles
// [RULE5] symbol error heeded at 100M only
// [RULE6] partner carrier: receive only in full duplex
// [RULE7] partner collision: low in full duplex
// [RULE8] pcs role: drive carrier sense output
// [RULE9] pcs role: drive collision output
// [RULE10] receive clock 25 or 2.5 MHz, phy side
// [RULE11] straps latched at reset release pick role
// [RULE12] mac role leaves shared pins undriven
`timescale 1ns/1ps

// ************************************************************
// nibble fifo
// ************************************************************
module nibble_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] count_ff;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // honest full and empty from the fill count
    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ff];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            if (pop) rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : nibble_fifo

// ************************************************************
// device end
// ************************************************************
module mii_rx_port_device (
    input wire logic clk,
    input wire logic rst,
    input wire logic expansion_bus_type_strap0,
    input wire logic expansion_bus_type_strap1,
    input wire logic speed_100,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [3:0] tx_nibble,
    input wire logic carrier_drive,
    input wire logic collision_drive,
    output logic [3:0] rx_nibble,
    output logic rx_error,
    output logic rx_strobe,
    output logic carrier_seen,
    output logic collision_seen,
    output logic pcs_role_active,
    mii_rx_link_if.dev_end link
);

    // ************************************************************
    // strap capture after reset release
    // ************************************************************
    logic [1:0] strap_s1_ff;
    logic [1:0] strap_s2_ff;
    mii_rx_pkg::boot_type boot_ff;
    mii_rx_pkg::boot_type nxt_boot;
    mii_rx_pkg::role_type role_ff;

    always_comb begin
        unique case (boot_ff)
            mii_rx_pkg::BOOT_SYNC0: nxt_boot = mii_rx_pkg::BOOT_SYNC1;
            mii_rx_pkg::BOOT_SYNC1: nxt_boot = mii_rx_pkg::BOOT_LATCH;
            mii_rx_pkg::BOOT_LATCH: nxt_boot = mii_rx_pkg::BOOT_RUN;
            mii_rx_pkg::BOOT_RUN: nxt_boot = mii_rx_pkg::BOOT_RUN;
        endcase
    end

    // straps pass two flops, then are latched once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_s1_ff <= mii_rx_pkg::STRAP_RESET;
            strap_s2_ff <= mii_rx_pkg::STRAP_RESET;
            boot_ff <= mii_rx_pkg::BOOT_SYNC0;
            role_ff <= mii_rx_pkg::ROLE_MAC;
        end else begin
            strap_s1_ff <= {expansion_bus_type_strap1, expansion_bus_type_strap0};
            strap_s2_ff <= strap_s1_ff;
            boot_ff <= nxt_boot;
            if (boot_ff == mii_rx_pkg::BOOT_LATCH) begin
                role_ff <= mii_rx_pkg::role_type'(strap_s2_ff[mii_rx_pkg::STRAP_ROLE_BIT]); // [RULE11]
            end
        end
    end

    wire running = (boot_ff == mii_rx_pkg::BOOT_RUN);
    wire pcs_run = running & (role_ff == mii_rx_pkg::ROLE_PCS);
    wire mac_run = running & (role_ff == mii_rx_pkg::ROLE_MAC);
    assign pcs_role_active = pcs_run;
    assign link.dev_oe = pcs_run; // [RULE12]

    // ************************************************************
    // pcs role: receive clock generator, clk domain
    // ************************************************************
    logic [mii_rx_pkg::DIV_W-1:0] div_ff;
    logic rclk_ff;
    wire [mii_rx_pkg::DIV_W-1:0] half_sel = speed_100 ? mii_rx_pkg::HALF_100_CYC :
                                                         mii_rx_pkg::HALF_10_CYC;
    wire half_end = (div_ff == half_sel - mii_rx_pkg::DIV_ONE);
    wire fall_tick = half_end & rclk_ff;

    // free-running divider, 25 or 2.5 MHz
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff <= mii_rx_pkg::DIV_RESET;
            rclk_ff <= 1'b0;
        end else begin
            div_ff <= half_end ? mii_rx_pkg::DIV_RESET : div_ff + mii_rx_pkg::DIV_ONE;
            if (half_end) rclk_ff <= ~rclk_ff; // [RULE10]
        end
    end

    // ************************************************************
    // pcs role: fifo feeds the nibble outputs
    // ************************************************************
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [3:0] fifo_out_data;
    wire fifo_pop = pcs_run & fall_tick;
    assign tx_ready = fifo_in_ready & pcs_run;

    nibble_fifo #(
        .WIDTH(mii_rx_pkg::FIFO_WIDTH),
        .DEPTH(mii_rx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(tx_valid & pcs_run),
        .in_ready(fifo_in_ready),
        .in_data(tx_nibble),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    logic [3:0] pnib_ff;
    logic pdv_ff;
    logic pcrs_ff;
    logic pcol_ff;
    logic pgate_ff;

    // outputs change on the falling clock edge, stable at the rising one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pnib_ff <= mii_rx_pkg::NIB_RESET;
            pdv_ff <= 1'b0;
            pcrs_ff <= 1'b0;
            pcol_ff <= 1'b0;
            pgate_ff <= 1'b0;
        end else if (fall_tick) begin
            pnib_ff <= fifo_out_valid ? fifo_out_data : mii_rx_pkg::NIB_RESET; // [RULE2]
            pdv_ff <= fifo_pop & fifo_out_valid; // [RULE4]
            pcrs_ff <= carrier_drive & pcs_run; // [RULE8]
            pcol_ff <= collision_drive & pcs_run; // [RULE9]
            pgate_ff <= pcs_run; // clock output starts at a low phase, no runt
        end
    end

    assign link.phy_role_rx_clock_out = rclk_ff & pgate_ff; // [RULE10]
    assign link.phy_role_rx_nibble_out = pnib_ff;
    assign link.phy_role_rx_valid_out = pdv_ff;
    assign link.phy_role_carrier_out = pcrs_ff;
    assign link.phy_role_collision_out = pcol_ff;

    // ************************************************************
    // mac role: capture on the partner's receive clock
    // ************************************************************
    logic act_s1_ff;
    logic act_s2_ff;
    logic spd_s1_ff;
    logic spd_s2_ff;
    logic [3:0] lnib_ff;
    logic lerr_ff;
    logic ltog_ff;
    wire take = act_s2_ff & link.mac_role_rx_valid_in; // [RULE3]

    // role and speed enter the link domain through two flops
    always_ff @(posedge link.mac_role_rx_clock_in or posedge rst) begin
        if (rst) begin
            act_s1_ff <= 1'b0;
            act_s2_ff <= 1'b0;
            spd_s1_ff <= 1'b0;
            spd_s2_ff <= 1'b0;
        end else begin
            act_s1_ff <= mac_run;
            act_s2_ff <= act_s1_ff;
            spd_s1_ff <= speed_100;
            spd_s2_ff <= spd_s1_ff;
        end
    end

    // nibble held until the next one, toggle marks each
    always_ff @(posedge link.mac_role_rx_clock_in or posedge rst) begin
        if (rst) begin
            lnib_ff <= mii_rx_pkg::NIB_RESET;
            lerr_ff <= 1'b0;
            ltog_ff <= 1'b0;
        end else if (take) begin
            lnib_ff <= link.mac_role_rx_nibble_in; // [RULE1]
            lerr_ff <= link.expansion_rx_symbol_error & spd_s2_ff; // [RULE5]
            ltog_ff <= ~ltog_ff;
        end
    end

    // ************************************************************
    // mac role: hand over to the system clock
    // ************************************************************
    logic tog_s1_ff;
    logic tog_s2_ff;
    logic tog_s3_ff;
    logic crs_s1_ff;
    logic crs_s2_ff;
    logic col_s1_ff;
    logic col_s2_ff;
    logic [3:0] rnib_ff;
    logic rerr_ff;
    logic rstb_ff;
    wire got = tog_s2_ff ^ tog_s3_ff;

    // toggle and status levels through two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_s1_ff <= 1'b0;
            tog_s2_ff <= 1'b0;
            tog_s3_ff <= 1'b0;
            crs_s1_ff <= 1'b0;
            crs_s2_ff <= 1'b0;
            col_s1_ff <= 1'b0;
            col_s2_ff <= 1'b0;
        end else begin
            tog_s1_ff <= ltog_ff;
            tog_s2_ff <= tog_s1_ff;
            tog_s3_ff <= tog_s2_ff;
            crs_s1_ff <= link.mac_role_carrier_in;
            crs_s2_ff <= crs_s1_ff;
            col_s1_ff <= link.mac_role_collision_in;
            col_s2_ff <= col_s1_ff;
        end
    end

    // nibble is stable for a whole link period when the toggle lands
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rnib_ff <= mii_rx_pkg::NIB_RESET;
            rerr_ff <= 1'b0;
            rstb_ff <= 1'b0;
        end else begin
            rstb_ff <= got;
            if (got) begin
                rnib_ff <= lnib_ff;
                rerr_ff <= lerr_ff;
            end
        end
    end

    assign rx_nibble = rnib_ff;
    assign rx_error = rerr_ff;
    assign rx_strobe = rstb_ff;
    assign carrier_seen = crs_s2_ff & mac_run;
    assign collision_seen = col_s2_ff & mac_run;

endmodule : mii_rx_port_device

// *** rtl/mii_rx_port_partner.sv ***
// partner of the switch port: external phy or external mac
// assumes phy_mode is the opposite of the switch's latched role
`timescale 1ns/1ps
module mii_rx_port_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic phy_mode,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic send_valid,
    output logic send_take,
    input wire logic [3:0] send_nibble,
    input wire logic send_error,
    input wire logic rx_activity,
    input wire logic tx_activity,
    input wire logic medium_collision,
    output logic [3:0] got_nibble,
    output logic got_strobe,
    output logic carrier_seen,
    output logic collision_seen,
    mii_rx_link_if.far_end link
);

    // ************************************************************
    // phy role: clock generator and pin drivers
    // ************************************************************
    logic [mii_rx_pkg::DIV_W-1:0] div_ff;
    logic rclk_ff;
    logic [3:0] nib_ff;
    logic dv_ff;
    logic er_ff;
    logic crs_ff;
    logic col_ff;
    wire [mii_rx_pkg::DIV_W-1:0] half_sel = speed_100 ? mii_rx_pkg::HALF_100_CYC :
                                                         mii_rx_pkg::HALF_10_CYC;
    wire half_end = (div_ff == half_sel - mii_rx_pkg::DIV_ONE);
    wire fall_tick = half_end & rclk_ff;
    wire carrier_now = full_duplex ? rx_activity : (rx_activity | tx_activity);

    assign send_take = fall_tick & phy_mode & send_valid;

    // free-running divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff <= mii_rx_pkg::DIV_RESET;
            rclk_ff <= 1'b0;
        end else begin
            div_ff <= half_end ? mii_rx_pkg::DIV_RESET : div_ff + mii_rx_pkg::DIV_ONE;
            if (half_end) rclk_ff <= ~rclk_ff; // [RULE10]
        end
    end

    // pins change on the falling edge, valid at the rising one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nib_ff <= mii_rx_pkg::NIB_RESET;
            dv_ff <= 1'b0;
            er_ff <= 1'b0;
            crs_ff <= 1'b0;
            col_ff <= 1'b0;
        end else if (fall_tick) begin
            nib_ff <= send_valid ? send_nibble : mii_rx_pkg::NIB_RESET; // [RULE1]
            dv_ff <= send_valid; // [RULE3]
            er_ff <= send_valid & send_error; // [RULE5]
            crs_ff <= carrier_now; // [RULE6]
            col_ff <= medium_collision & ~full_duplex; // [RULE7]
        end
    end

    assign link.far_oe = phy_mode;
    assign link.far_clock_o = rclk_ff;
    assign link.far_nibble_o = nib_ff;
    assign link.far_valid_o = dv_ff;
    assign link.far_error_o = er_ff;
    assign link.far_carrier_o = crs_ff;
    assign link.far_collision_o = col_ff;

    // ************************************************************
    // mac role: capture on the switch's clock, hand over by toggle
    // ************************************************************
    logic [3:0] lnib_ff;
    logic ltog_ff;
    logic tog_s1_ff;
    logic tog_s2_ff;
    logic tog_s3_ff;
    logic crs_s1_ff;
    logic crs_s2_ff;
    logic col_s1_ff;
    logic col_s2_ff;
    logic [3:0] rnib_ff;
    logic rstb_ff;

    // accept only valid nibbles
    always_ff @(posedge link.mac_role_rx_clock_in or posedge rst) begin
        if (rst) begin
            lnib_ff <= mii_rx_pkg::NIB_RESET;
            ltog_ff <= 1'b0;
        end else if (link.mac_role_rx_valid_in) begin
            lnib_ff <= link.mac_role_rx_nibble_in; // [RULE2]
            ltog_ff <= ~ltog_ff; // [RULE4]
        end
    end

    // two-flop crossings into the system clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_s1_ff <= 1'b0;
            tog_s2_ff <= 1'b0;
            tog_s3_ff <= 1'b0;
            crs_s1_ff <= 1'b0;
            crs_s2_ff <= 1'b0;
            col_s1_ff <= 1'b0;
            col_s2_ff <= 1'b0;
            rnib_ff <= mii_rx_pkg::NIB_RESET;
            rstb_ff <= 1'b0;
        end else begin
            tog_s1_ff <= ltog_ff;
            tog_s2_ff <= tog_s1_ff;
            tog_s3_ff <= tog_s2_ff;
            crs_s1_ff <= link.mac_role_carrier_in; // [RULE8]
            crs_s2_ff <= crs_s1_ff;
            col_s1_ff <= link.mac_role_collision_in; // [RULE9]
            col_s2_ff <= col_s1_ff;
            rstb_ff <= tog_s2_ff ^ tog_s3_ff;
            if (tog_s2_ff ^ tog_s3_ff) rnib_ff <= lnib_ff;
        end
    end

    assign got_nibble = rnib_ff;
    assign got_strobe = rstb_ff;
    assign carrier_seen = crs_s2_ff & ~phy_mode;
    assign collision_seen = col_s2_ff & ~phy_mode;

endmodule : mii_rx_port_partner

// *** test/mii_rx_assertions.sv ***
// checker for the receive link pins between the two ends
// assumes plain copies of the link interface signals and the system clock
`timescale 1ns/1ps
module mii_rx_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic dev_oe,
    input wire logic phy_role_rx_clock_out,
    input wire logic [3:0] phy_role_rx_nibble_out,
    input wire logic phy_role_rx_valid_out,
    input wire logic phy_role_carrier_out,
    input wire logic phy_role_collision_out,
    input wire logic far_oe,
    input wire logic far_clock_o,
    input wire logic [3:0] far_nibble_o,
    input wire logic far_valid_o
);
    // ************
    // link rules
    // ************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // role holds from latch until the next reset
    property p_role_held;
        !$fell(dev_oe);
    endproperty
    a_role_held: assert property (p_role_held) else $error("role dropped");

    // mac role leaves clock and valid low
    property p_mac_quiet;
        !dev_oe |-> !phy_role_rx_clock_out && !phy_role_rx_valid_out;
    endproperty
    a_mac_quiet: assert property (p_mac_quiet) else $error("mac role drives");

    // generated clock: high half of 2 to 20 cycles
    property p_dev_clk;
        $rose(phy_role_rx_clock_out) |-> phy_role_rx_clock_out[*2] ##[1:19] !phy_role_rx_clock_out;
    endproperty
    a_dev_clk: assert property (p_dev_clk) else $error("device clock half");

    // partner clock: same bounds
    property p_far_clk;
        $rose(far_clock_o) |-> far_clock_o[*2] ##[1:19] !far_clock_o;
    endproperty
    a_far_clk: assert property (p_far_clk) else $error("partner clock half");

    // nibble moves only on the falling link edge
    property p_nib_align;
        dev_oe && $changed(phy_role_rx_nibble_out) |-> $fell(phy_role_rx_clock_out);
    endproperty
    a_nib_align: assert property (p_nib_align) else $error("nibble off edge");

    // valid moves only on the falling link edge
    property p_valid_align;
        dev_oe && $changed(phy_role_rx_valid_out) |-> $fell(phy_role_rx_clock_out);
    endproperty
    a_valid_align: assert property (p_valid_align) else $error("valid off edge");

    // carrier and collision move with the link clock
    property p_status_align;
        dev_oe && ($changed(phy_role_carrier_out) || $changed(phy_role_collision_out))
            |-> $fell(phy_role_rx_clock_out);
    endproperty
    a_status_align: assert property (p_status_align) else $error("status off edge");

    // partner data stable around the rising edge
    property p_far_align;
        far_oe && ($changed(far_nibble_o) || $changed(far_valid_o)) |-> $fell(far_clock_o);
    endproperty
    a_far_align: assert property (p_far_align) else $error("partner data off edge");
endmodule : mii_rx_assertions

// *** test/tb_port4_mii_receive_side.sv ***
// self-checking bench: device and partner joined by the link interface
// assumes design files, package and interface are compiled first
`timescale 1ns/1ps
module tb_port4_mii_receive_side;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strap0 = 1'b0;
    logic speed_100 = 1'b1;
    logic tx_valid = 1'b0;
    logic [3:0] tx_nibble = 4'h0;
    logic carrier_drive = 1'b0;
    logic collision_drive = 1'b0;
    logic phy_mode = 1'b0;
    logic full_duplex = 1'b0;
    logic send_valid = 1'b0;
    logic [3:0] send_nibble = 4'h0;
    logic send_error = 1'b0;
    logic rx_activity = 1'b0;
    logic tx_activity = 1'b0;
    logic medium_collision = 1'b0;
    logic tx_ready, rx_error, rx_strobe, dev_crs, dev_col, pcs_on;
    logic send_take, got_strobe, far_crs, far_col;
    logic [3:0] rx_nibble, got_nibble;
    logic [4:0] rx_q[$];
    logic [3:0] got_q[$];
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    // ************
    // structure
    // ************
    mii_rx_link_if link ();
    mii_rx_port_device u_mii_rx_port_device (
        .clk(clk), .rst(rst), .expansion_bus_type_strap0(strap0),
        .expansion_bus_type_strap1(1'b0), .speed_100(speed_100), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_nibble(tx_nibble), .carrier_drive(carrier_drive),
        .collision_drive(collision_drive), .rx_nibble(rx_nibble), .rx_error(rx_error),
        .rx_strobe(rx_strobe), .carrier_seen(dev_crs), .collision_seen(dev_col),
        .pcs_role_active(pcs_on), .link(link.dev_end));
    mii_rx_port_partner u_mii_rx_port_partner (
        .clk(clk), .rst(rst), .phy_mode(phy_mode), .speed_100(speed_100),
        .full_duplex(full_duplex), .send_valid(send_valid), .send_take(send_take),
        .send_nibble(send_nibble), .send_error(send_error), .rx_activity(rx_activity),
        .tx_activity(tx_activity), .medium_collision(medium_collision),
        .got_nibble(got_nibble), .got_strobe(got_strobe), .carrier_seen(far_crs),
        .collision_seen(far_col), .link(link.far_end));
    mii_rx_assertions u_mii_rx_assertions (
        .clk(clk), .rst(rst), .dev_oe(link.dev_oe), .far_oe(link.far_oe),
        .phy_role_rx_clock_out(link.phy_role_rx_clock_out),
        .phy_role_rx_nibble_out(link.phy_role_rx_nibble_out),
        .phy_role_rx_valid_out(link.phy_role_rx_valid_out),
        .phy_role_carrier_out(link.phy_role_carrier_out),
        .phy_role_collision_out(link.phy_role_collision_out),
        .far_clock_o(link.far_clock_o), .far_nibble_o(link.far_nibble_o),
        .far_valid_o(link.far_valid_o));
    always #(mii_rx_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    // collect deliveries; the run needs under 20000 cycles
    always @(posedge clk) begin
        if (rx_strobe === 1'b1) rx_q.push_back({rx_error, rx_nibble});
        if (got_strobe === 1'b1) got_q.push_back(got_nibble);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // ************
    // helpers
    // ************
    task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // reset with straps and partner role set opposite
    task automatic do_reset(input logic pcs, input logic spd);
        rst = 1'b1;
        strap0 = pcs;
        phy_mode = ~pcs;
        speed_100 = spd;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1 rx_q.delete();
        got_q.delete();
    endtask : do_reset

    // ************
    // scenarios
    // ************
    // fill the fifo until refused, then match the partner's nibbles
    task automatic t_pcs_fill();
        int n;
        do_reset(1'b1, 1'b1);
        check("pcs role", {3'h0, pcs_on, link.dev_oe}, 5'h03);
        n = 0;
        tx_valid = 1'b1;
        tx_nibble = 4'h0;
        while (tx_ready === 1'b1) begin
            @(posedge clk) #1;
            n++;
            tx_nibble = 4'(n * 7);
        end
        tx_valid = 1'b0;
        wait (got_q.size() >= n);
        repeat (20) @(posedge clk) #1;
        check("nibble count", 5'(got_q.size()), 5'(n));
        for (int i = 0; i < n; i++) begin
            check("pcs nibble", {1'b0, got_q[i]}, {1'b0, 4'(i * 7)});
        end
    endtask : t_pcs_fill

    // carrier and collision outputs reach the external mac
    task automatic t_pcs_status();
        for (int i = 0; i < 4; i++) begin
            carrier_drive = i[0];
            collision_drive = i[1];
            repeat (16) @(posedge clk);
            #1 check("far carrier", {4'h0, far_crs}, {4'h0, i[0]});
            check("far collision", {4'h0, far_col}, {4'h0, i[1]});
        end
    endtask : t_pcs_status

    // mac role receive with error flags; waits out the role sync first
    task automatic t_mac_rx(input logic spd);
        do_reset(1'b0, spd);
        check("mac quiet", {3'h0, pcs_on, link.dev_oe}, 5'h00);
        repeat (130) @(posedge clk) #1;
        send_valid = 1'b1;
        for (int i = 0; i < 6; i++) begin
            send_nibble = 4'(i * 5 + 3);
            send_error = i[0];
            while (send_take !== 1'b1) @(posedge clk) #1;
            @(posedge clk) #1;
        end
        send_valid = 1'b0;
        wait (rx_q.size() >= 6);
        repeat (80) @(posedge clk) #1;
        check("rx count", 5'(rx_q.size()), 5'h06);
        for (int i = 0; i < 6; i++) begin
            check("rx nibble", rx_q[i], {spd & i[0], 4'(i * 5 + 3)});
        end
    endtask : t_mac_rx

    // partner carrier and collision per duplex mode
    task automatic t_mac_status();
        logic [5:0] row [4];
        row = '{6'b001111, 6'b101100, 6'b110010, 6'b000000};
        for (int i = 0; i < 4; i++) begin
            {full_duplex, rx_activity, tx_activity, medium_collision} = row[i][5:2];
            repeat (60) @(posedge clk);
            #1 check("carrier", {4'h0, dev_crs}, {4'h0, row[i][1]});
            check("collision", {4'h0, dev_col}, {4'h0, row[i][0]});
        end
    endtask : t_mac_status
    initial begin
        t_pcs_fill();
        t_pcs_status();
        t_mac_rx(1'b1);
        t_mac_rx(1'b0);
        t_mac_status();
        end_sim();
    end
endmodule : tb_port4_mii_receive_side
